// >>> include/pmr_pkg.sv
// Constants and types shared by the power management register bank.
// Assumes a 32-bit APB with byte addresses and one word per register.
package pmr_pkg;

    //////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] PMR_OFS_PM_CMD_STATUS = 8'h90;
    localparam logic [7:0] PMR_OFS_TX_WORK_PTR   = 8'h94;
    localparam logic [7:0] PMR_OFS_RX_WORK_PTR   = 8'h98;
    localparam logic [7:0] PMR_OFS_IRQ_STATUS    = 8'hC0;
    localparam logic [7:0] PMR_OFS_IRQ_MASK      = 8'hC4;

    //////////////////////////////////////////////////////////////////////
    // Power management command and status fields
    localparam int PMR_BIT_WAKE_STATUS  = 15;
    localparam int PMR_BIT_WAKE_ENABLE  = 8;
    localparam int PMR_SCALE_HI         = 14;
    localparam int PMR_SCALE_LO         = 13;
    localparam int PMR_SELECT_HI        = 12;
    localparam int PMR_SELECT_LO        = 9;
    localparam int PMR_STATE_HI         = 1;
    localparam int PMR_STATE_LO         = 0;
    localparam logic [1:0] PMR_SCALE_VALUE  = 2'h0;
    localparam logic [3:0] PMR_SELECT_VALUE = 4'h0;

    // Power state encodings
    localparam logic [1:0] PMR_STATE_D0    = 2'h0;
    localparam logic [1:0] PMR_STATE_D1    = 2'h1;
    localparam logic [1:0] PMR_STATE_D2    = 2'h2;
    localparam logic [1:0] PMR_STATE_D3HOT = 2'h3;

    // Reset values
    localparam logic [31:0] PMR_RESET_PM_CMD_STATUS = 32'h0000_0000;
    localparam logic [2:0]  PMR_RESET_IRQ           = 3'h0;

    //////////////////////////////////////////////////////////////////////
    // Interrupt status / mask bit positions
    localparam int PMR_IRQ_WAKE      = 0;
    localparam int PMR_IRQ_BAD_STATE = 1;
    localparam int PMR_IRQ_STATE_CHG = 2;
    localparam int PMR_IRQ_BITS      = 3;

    typedef enum {
        PMR_SEL_NONE,
        PMR_SEL_PM_CMD_STATUS,
        PMR_SEL_TX_WORK_PTR,
        PMR_SEL_RX_WORK_PTR,
        PMR_SEL_IRQ_STATUS,
        PMR_SEL_IRQ_MASK
    } pmr_sel_type;

    // Address decode, shared by the read mux and the write path
    function automatic pmr_sel_type pmr_decode(input logic [7:0] addr);
        pmr_sel_type sel;
        sel = PMR_SEL_NONE;
        if (addr == PMR_OFS_PM_CMD_STATUS) sel = PMR_SEL_PM_CMD_STATUS;
        if (addr == PMR_OFS_TX_WORK_PTR)   sel = PMR_SEL_TX_WORK_PTR;
        if (addr == PMR_OFS_RX_WORK_PTR)   sel = PMR_SEL_RX_WORK_PTR;
        if (addr == PMR_OFS_IRQ_STATUS)    sel = PMR_SEL_IRQ_STATUS;
        if (addr == PMR_OFS_IRQ_MASK)      sel = PMR_SEL_IRQ_MASK;
        return sel;
    endfunction : pmr_decode

endpackage : pmr_pkg

// >>> include/pmr_bus_if.sv
// Internal register access path between the APB front end and the bank.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface pmr_bus_if;
    logic        wr_en;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  strb;
    logic [31:0] rdata;
    logic        hit;

    modport front (output wr_en, output addr, output wdata, output strb,
                   input rdata, input hit);
    modport bank  (input wr_en, input addr, input wdata, input strb,
                   output rdata, output hit);
endinterface : pmr_bus_if

// >>> rtl/pmr_apb_slave.sv
// APB front end: one wait state, registered answer, error on unmapped.
// Assumes the bank answers rdata and hit combinationally from addr.
`timescale 1ns/100ps
module pmr_apb_slave
    import pmr_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    pmr_bus_if.front         bus
);

    typedef struct packed {
        logic        ready;
        logic [31:0] rdata;
        logic        err;
    } pmr_front_type;

    pmr_front_type state;
    pmr_front_type next_state;

    //////////////////////////////////////////////////////////////////////
    // Read data and error are sampled at the same edge that raises pready
    always_comb begin
        next_state       = state;
        next_state.ready = 1'b0;
        // Error only stands with pready, never beyond the transfer
        next_state.err   = 1'b0;
        if (psel && penable && !state.ready) begin
            next_state.ready = 1'b1;
            next_state.rdata = pwrite ? 32'h0000_0000 : bus.rdata;
            next_state.err   = !bus.hit;
        end
    end

    // Write lands at the completing edge only
    assign bus.wr_en = psel && penable && pwrite && state.ready && !state.err;
    assign bus.addr  = paddr;
    assign bus.wdata = pwdata;
    assign bus.strb  = pstrb;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pready  = state.ready;
    assign prdata  = state.rdata;
    assign pslverr = state.err;

endmodule : pmr_apb_slave

// >>> rtl/pmr_regs.sv
// Power management command/status and working descriptor pointer bank.
// Assumes APB from the host, wake events and pointers from same-clock logic.
//
// Notes on behaviour
// - Wake event sets wake status regardless of enable
// - Write one clears wake status; zero ignored
// - Wake status resets to zero
// - Scale and select fields always read zero
// - Two-bit power state, read and written
// - Unsupported state write discarded, bus completes
// - Transmit working pointer readable, 32 bits
// - Receive working pointer readable, 32 bits
// - Config space view mirrors the register
`timescale 1ns/100ps
module pmr_regs
    import pmr_pkg::*;
#(
    // Bit n set: power state n may be entered by a write
    parameter logic [3:0] SUPPORTED_STATES = 4'h9
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        wake_event,
    input  wire logic [31:0] tx_working_desc_ptr,
    input  wire logic [31:0] rx_working_desc_ptr,
    output logic             wake_event_out_n,
    output logic [31:0]      config_space_pm_mirror,
    output logic [1:0]       power_state_field,
    output logic             irq
);

    //////////////////////////////////////////////////////////////////////
    // Parameter check

    generate
        if (!SUPPORTED_STATES[PMR_STATE_D0]) begin : g_bad_states
            $error("pmr_regs: state D0 must always be supported");
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////
    // Front end

    pmr_bus_if bus ();

    pmr_apb_slave u_front (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .pready  (pready),
        .prdata  (prdata),
        .pslverr (pslverr),
        .bus     (bus)
    );

    //////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic                    wake_event_status;
        logic                    wake_output_enable;
        logic [1:0]              power_state_field;
        logic [PMR_IRQ_BITS-1:0] irq_status;
        logic [PMR_IRQ_BITS-1:0] irq_mask;
        logic                    wake_out_n;
        logic [31:0]             mirror;
        logic                    irq;
    } pmr_state_type;

    pmr_state_type state;
    pmr_state_type next_state;

    // Assembled word of the command/status register
    function automatic logic [31:0] pmr_pack_pmcsr(input logic       status,
                                                   input logic       enable,
                                                   input logic [1:0] pstate);
        logic [31:0] word;
        word = 32'h0000_0000;
        word[PMR_BIT_WAKE_STATUS]          = status;
        word[PMR_SCALE_HI:PMR_SCALE_LO]    = PMR_SCALE_VALUE;
        word[PMR_SELECT_HI:PMR_SELECT_LO]  = PMR_SELECT_VALUE;
        word[PMR_BIT_WAKE_ENABLE]          = enable;
        word[PMR_STATE_HI:PMR_STATE_LO]    = pstate;
        return word;
    endfunction : pmr_pack_pmcsr

    //////////////////////////////////////////////////////////////////////
    // Read side

    pmr_sel_type sel;
    logic [31:0] pmcsr_word;

    always_comb begin
        sel        = pmr_decode(bus.addr);
        pmcsr_word = pmr_pack_pmcsr(state.wake_event_status,
                                    state.wake_output_enable,
                                    state.power_state_field);
        bus.hit    = (sel != PMR_SEL_NONE);
        unique case (sel)
            PMR_SEL_PM_CMD_STATUS: begin
                bus.rdata = pmcsr_word;
            end
            PMR_SEL_TX_WORK_PTR: begin
                bus.rdata = tx_working_desc_ptr;
            end
            PMR_SEL_RX_WORK_PTR: begin
                bus.rdata = rx_working_desc_ptr;
            end
            PMR_SEL_IRQ_STATUS: begin
                bus.rdata = {{(32-PMR_IRQ_BITS){1'b0}}, state.irq_status};
            end
            PMR_SEL_IRQ_MASK: begin
                bus.rdata = {{(32-PMR_IRQ_BITS){1'b0}}, state.irq_mask};
            end
            PMR_SEL_NONE: begin
                bus.rdata = 32'h0000_0000;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////
    // Write side and events

    logic                    wr_pm;
    logic                    wr_stat;
    logic                    wr_mask;
    logic [1:0]              req_state;
    logic                    state_ok;
    logic                    state_write;
    logic [PMR_IRQ_BITS-1:0] irq_set;

    always_comb begin
        next_state  = state;
        wr_pm       = bus.wr_en && (sel == PMR_SEL_PM_CMD_STATUS);
        wr_stat     = bus.wr_en && (sel == PMR_SEL_IRQ_STATUS) && bus.strb[0];
        wr_mask     = bus.wr_en && (sel == PMR_SEL_IRQ_MASK) && bus.strb[0];
        req_state   = bus.wdata[PMR_STATE_HI:PMR_STATE_LO];
        state_ok    = SUPPORTED_STATES[req_state];
        state_write = wr_pm && bus.strb[0];
        irq_set     = '0;

        // Clear first so that a same-cycle event still sets
        if (wr_pm && bus.strb[1] && bus.wdata[PMR_BIT_WAKE_STATUS]) begin
            next_state.wake_event_status = 1'b0;
        end
        if (wake_event) begin
            next_state.wake_event_status = 1'b1;
            irq_set[PMR_IRQ_WAKE]        = 1'b1;
        end

        if (wr_pm && bus.strb[1]) begin
            next_state.wake_output_enable = bus.wdata[PMR_BIT_WAKE_ENABLE];
        end

        // Unsupported state: the bus still completes, the value is dropped
        if (state_write) begin
            if (state_ok) begin
                next_state.power_state_field = req_state;
                if (req_state != state.power_state_field) begin
                    irq_set[PMR_IRQ_STATE_CHG] = 1'b1;
                end
            end else begin
                irq_set[PMR_IRQ_BAD_STATE] = 1'b1;
            end
        end

        // Sticky status, write one to clear, set wins
        if (wr_stat) begin
            next_state.irq_status = state.irq_status & ~bus.wdata[PMR_IRQ_BITS-1:0];
        end
        next_state.irq_status = next_state.irq_status | irq_set;
        if (wr_mask) begin
            next_state.irq_mask = bus.wdata[PMR_IRQ_BITS-1:0];
        end

        next_state.irq = |(next_state.irq_status & next_state.irq_mask);

        next_state.wake_out_n = !(next_state.wake_event_status
                                  && next_state.wake_output_enable);

        next_state.mirror = pmr_pack_pmcsr(next_state.wake_event_status,
                                           next_state.wake_output_enable,
                                           next_state.power_state_field);
    end

    //////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state.wake_event_status  <= PMR_RESET_PM_CMD_STATUS[PMR_BIT_WAKE_STATUS];
            state.wake_output_enable <= PMR_RESET_PM_CMD_STATUS[PMR_BIT_WAKE_ENABLE];
            state.power_state_field  <= PMR_RESET_PM_CMD_STATUS[PMR_STATE_HI:PMR_STATE_LO];
            state.irq_status         <= PMR_RESET_IRQ;
            state.irq_mask           <= PMR_RESET_IRQ;
            state.wake_out_n         <= 1'b1;
            state.mirror             <= PMR_RESET_PM_CMD_STATUS;
            state.irq                <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign wake_event_out_n       = state.wake_out_n;
    assign config_space_pm_mirror = state.mirror;
    assign power_state_field      = state.power_state_field;
    assign irq                    = state.irq;

endmodule : pmr_regs

// >>> bench/pmr_wake_src.sv
// Model of the wake logic and the DMA pointer sources.
// Assumes the same clock as the register bank.
`timescale 1ns/100ps
module pmr_wake_src (
    input  wire logic  ref_clk,
    output logic        wake_event,
    output logic [31:0] tx_working_desc_ptr,
    output logic [31:0] rx_working_desc_ptr
);
    initial begin
        wake_event = 1'b0;
        tx_working_desc_ptr = 32'h0;
        rx_working_desc_ptr = 32'h0;
    end

    // One-cycle pulse, as the wake logic gives it
    task pulse;
        @(posedge ref_clk);
        wake_event <= 1'b1;
        @(posedge ref_clk);
        wake_event <= 1'b0;
    endtask : pulse

    task load(input logic [31:0] t, input logic [31:0] r);
        @(posedge ref_clk);
        tx_working_desc_ptr <= t;
        rx_working_desc_ptr <= r;
    endtask : load
endmodule : pmr_wake_src

// >>> bench/pmr_regs_chk.sv
// Port checker for the power management register bank.
// Assumes binding to pmr_regs with the same state parameter.
`timescale 1ns/100ps
module pmr_regs_chk
    import pmr_pkg::*;
#(
    parameter logic [3:0] SUPPORTED_STATES = 4'h9
) (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        wake_event,
    input wire logic        wake_event_out_n,
    input wire logic [31:0] config_space_pm_mirror,
    input wire logic [1:0]  power_state_field
);
    wire logic [31:0] pm = config_space_pm_mirror;
    wire logic [1:0]  ws = pwdata[1:0];
    wire logic wr = psel && penable && pready && pwrite && paddr == PMR_OFS_PM_CMD_STATUS;
    wire logic clr = wr && pstrb[1] && pwdata[15];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    //////////////////////////////////////////////////////////////////////
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    property p_answer; s_setup ##1 s_access |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer after one wait");
    property p_rst; $rose(resetn) |-> pm == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("mirror not zero after reset");
    property p_set; wake_event |=> pm[15]; endproperty
    a_set: assert property (p_set) else $error("wake status not set");
    property p_clr; clr && !wake_event |=> !pm[15]; endproperty
    a_clr: assert property (p_clr) else $error("wake status not cleared");
    property p_keep; pm[15] && !clr |=> pm[15]; endproperty
    a_keep: assert property (p_keep) else $error("wake status lost");
    property p_out; wake_event_out_n == !(pm[15] && pm[8]); endproperty
    a_out: assert property (p_out) else $error("wake output wrong");
    property p_zero; pm[31:9] == 23'h0 || pm[31:9] == 23'h40; endproperty
    a_zero: assert property (p_zero) else $error("unimplemented bits set");
    property p_state; power_state_field == pm[1:0] && pm[7:2] == 6'h0; endproperty
    a_state: assert property (p_state) else $error("mirror state differs");
    property p_good; wr && pstrb[0] && SUPPORTED_STATES[ws] |=> power_state_field == $past(ws);
    endproperty
    a_good: assert property (p_good) else $error("state not taken");
    property p_bad; wr && pstrb[0] && !SUPPORTED_STATES[ws] |=> $stable(power_state_field);
    endproperty
    a_bad: assert property (p_bad) else $error("bad state taken");
endmodule : pmr_regs_chk

bind pmr_regs pmr_regs_chk #(.SUPPORTED_STATES(SUPPORTED_STATES)) u_chk (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .wake_event(wake_event), .wake_event_out_n(wake_event_out_n),
    .config_space_pm_mirror(config_space_pm_mirror), .power_state_field(power_state_field)
);

// >>> bench/pmr_regs_tb.sv
// Testbench for the power management register bank over APB.
// Assumes the wake source model and the bound port checker.
`timescale 1ns/100ps
module pmr_regs_tb
    import pmr_pkg::*;
;
    localparam logic [3:0] SUP = 4'h9;
    logic        ref_clk, resetn, psel, penable, pwrite, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, tx_ptr, rx_ptr, mirror, rd;
    logic [3:0]  pstrb;
    logic        pready, pslverr, wake_event, wake_event_out_n, irq;
    logic [1:0]  state, cur;
    int          errors, compares;

    pmr_regs #(.SUPPORTED_STATES(SUP)) u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .wake_event(wake_event),
        .tx_working_desc_ptr(tx_ptr), .rx_working_desc_ptr(rx_ptr),
        .wake_event_out_n(wake_event_out_n), .config_space_pm_mirror(mirror),
        .power_state_field(state), .irq(irq)
    );
    pmr_wake_src u_src (.ref_clk(ref_clk), .wake_event(wake_event),
        .tx_working_desc_ptr(tx_ptr), .rx_working_desc_ptr(rx_ptr));

    //////////////////////////////////////////////////////////////////////
    task summarize;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: word %h, wanted %h", $time, g, e);
        end
    endtask : chk

    task chk_pin(input logic g, input logic e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: pin %b, wanted %b", $time, g, e);
        end
    endtask : chk_pin

    // Ends on the falling edge so registered effects have landed
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // No cycle count assumed: waits for pready, and only the watchdog ends a hung wait
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge ref_clk);
    endtask : xfer

    //////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (4000) @(posedge ref_clk);
        errors++;
        summarize();
    end

    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        @(negedge ref_clk);
        chk(mirror, 32'h0);
        chk_pin(wake_event_out_n, 1'b1);
        u_src.load(32'h1234_5678, 32'h9ABC_DEF0);
        xfer(1'b1, PMR_OFS_TX_WORK_PTR, 32'hFFFF_FFFF);
        xfer(1'b0, PMR_OFS_TX_WORK_PTR, 32'h0);
        chk(rd, 32'h1234_5678);
        xfer(1'b0, PMR_OFS_RX_WORK_PTR, 32'h0);
        chk(rd, 32'h9ABC_DEF0);
        xfer(1'b0, 8'h9C, 32'h0);
        chk_pin(err, 1'b1);
        chk(rd, 32'h0);
        cur = PMR_STATE_D0;
        // Descending so the unsupported states follow a live one
        for (int s = 3; s >= 0; s--) begin
            xfer(1'b1, PMR_OFS_PM_CMD_STATUS, 32'hFFFF_7F00 | s);
            if (SUP[s]) cur = s[1:0];
            chk_pin(err, 1'b0);
            chk({30'h0, state}, {30'h0, cur});
            xfer(1'b0, PMR_OFS_PM_CMD_STATUS, 32'h0);
            chk(rd, {23'h0, 1'b1, 6'h0, cur});
            chk(mirror, rd);
        end
        u_src.pulse();
        @(negedge ref_clk);
        chk_pin(wake_event_out_n, 1'b0);
        xfer(1'b1, PMR_OFS_PM_CMD_STATUS, 32'h0000_0100);
        chk(mirror, 32'h0000_8100);
        xfer(1'b1, PMR_OFS_PM_CMD_STATUS, 32'h0000_8000);
        chk(mirror, 32'h0);
        u_src.pulse();
        @(negedge ref_clk);
        chk(mirror, 32'h0000_8000);
        chk_pin(wake_event_out_n, 1'b1);
        chk_pin(irq, 1'b0);
        xfer(1'b1, PMR_OFS_IRQ_MASK, 32'h1);
        chk_pin(irq, 1'b1);
        xfer(1'b1, PMR_OFS_IRQ_MASK, 32'h0);
        chk_pin(irq, 1'b0);
        xfer(1'b0, PMR_OFS_IRQ_STATUS, 32'h0);
        chk(rd, 32'h7);
        xfer(1'b1, PMR_OFS_IRQ_STATUS, 32'h7);
        xfer(1'b1, PMR_OFS_IRQ_MASK, 32'h7);
        chk_pin(irq, 1'b0);
        u_src.pulse();
        @(negedge ref_clk);
        chk_pin(irq, 1'b1);
        chk(mirror, 32'h0000_8000);
        // Mid-run reset with wake status set must clear it again
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        @(negedge ref_clk);
        chk(mirror, 32'h0);
        chk_pin(wake_event_out_n, 1'b1);
        chk_pin(irq, 1'b0);
        summarize();
    end
endmodule : pmr_regs_tb
